// ==== src/compare_branch_load_exec.sv ====
`timescale 1ns/10ps

// Summary of operation
// - Compares subtract without storing, update Z N V C H, finish in one cycle.
// - Register bit skip tests a bit, skips by 2 or 3, flags unchanged.
// - I/O bit skip tests an I/O bit likewise, flags unchanged.
// - Flag branch jumps to PC plus offset plus one when flag matches polarity.
// - Carry branches test carry set or clear with same target and cost.
// - Signed greater-or-equal branch taken when N xor V is zero.
// - Signed less-than branch taken when N xor V is one.
// - Half-carry branches test H set or clear, target PC plus offset plus one.
// - Transfer-bit branches test T set or clear, same target.
// - Overflow branches test V set or clear, same target and cost.
// - Interrupt-state branches test I set or clear, one or two cycles.
// - Post-increment load reads at pointer, then pointer plus one, two cycles.
// - Pre-decrement load decrements pointer first, then reads, two cycles.
// - Displacement load reads X, Y or Z plus offset, pointer kept, two cycles.
module compare_branch_load_exec #(
  parameter int PC_W = 12
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Instruction request; io_rdata holds the I/O register named by the request.
  input wire logic req_valid,
  input wire cbl_pkg::instr_t req,
  input wire logic [7:0] io_rdata,
  output logic req_ready_q,
  output logic done_q,
  // Flag load from neighbouring units.
  input wire logic flags_wr_en,
  input wire logic [7:0] flags_wr_val,
  output logic [7:0] status_flags_reg_q,
  output logic [PC_W-1:0] pc_q,
  // Data memory read, answered combinationally while the strobe is high.
  output logic dmem_rd_q,
  output logic [15:0] dmem_addr_q,
  input wire logic [7:0] dmem_rdata,
  // Register file write observation.
  output cbl_pkg::rf_wr_t rf_wr_q
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {st_idle, st_stall, st_load} state_t;

  state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic [4:0] dst_q, dst_d;
  logic [PC_W-1:0] pc_d;
  logic [7:0] flags_d;
  logic ready_d, done_d, dmem_rd_d;
  logic [15:0] dmem_addr_d;
  cbl_pkg::rf_wr_t wr_d;
  logic [7:0] rf [cbl_pkg::REG_CNT];

  logic accept, cond, hit;
  logic [7:0] a_v, b_v, res;
  logic [8:0] diff;
  logic [15:0] ptr, ptr_new;
  logic [PC_W-1:0] tgt;

  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    unique case (sel)
      cbl_pkg::PTR_X: ptr_lo = cbl_pkg::PTR_X_LO;
      cbl_pkg::PTR_Y: ptr_lo = cbl_pkg::PTR_Y_LO;
      default: ptr_lo = cbl_pkg::PTR_Z_LO;
    endcase
  endfunction

  // Flag test; S is rebuilt from N and V so a stale S cannot mislead it.
  function automatic logic flag_of(input logic [7:0] f, input logic [2:0] sel);
    if (sel == 3'(cbl_pkg::FLAG_S)) begin
      flag_of = f[cbl_pkg::FLAG_N] ^ f[cbl_pkg::FLAG_V];
    end else begin
      flag_of = f[sel];
    end
  endfunction

  assign accept = req_valid && req_ready_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    dst_d = dst_q;
    pc_d = pc_q;
    flags_d = flags_wr_en ? flags_wr_val : status_flags_reg_q;
    done_d = 1'b0;
    dmem_rd_d = 1'b0;
    dmem_addr_d = dmem_addr_q;
    wr_d = '0;
    a_v = rf[req.rd];
    b_v = (req.op == cbl_pkg::op_compare_immediate) ? req.imm : rf[req.rr];
    diff = {1'b0, a_v} - {1'b0, b_v}
         - {8'h00, (req.op == cbl_pkg::op_compare_regs_with_carry) && status_flags_reg_q[cbl_pkg::FLAG_C]};
    res = diff[7:0];
    ptr = {rf[ptr_lo(req.ptr_sel) + 5'h01], rf[ptr_lo(req.ptr_sel)]};
    ptr_new = ptr;
    hit = ((req.op == cbl_pkg::op_skip_io_bit) ? io_rdata[req.bit_sel] : b_v[req.bit_sel]) == req.pol_set;
    cond = flag_of(status_flags_reg_q, req.flag_sel) == req.pol_set;
    tgt = pc_q + PC_W'(cbl_pkg::PC_STEP) + {{(PC_W-7){req.offset[6]}}, req.offset};
    unique case (state_q)
      st_idle: begin
        if (accept) begin
          pc_d = pc_q + PC_W'(cbl_pkg::PC_STEP);
          done_d = 1'b1;
          unique case (req.op)
            cbl_pkg::op_compare_regs, cbl_pkg::op_compare_regs_with_carry, cbl_pkg::op_compare_immediate: begin
              flags_d[cbl_pkg::FLAG_H] = (~a_v[3] & b_v[3]) | (b_v[3] & res[3]) | (res[3] & ~a_v[3]);
              flags_d[cbl_pkg::FLAG_V] = (a_v[7] & ~b_v[7] & ~res[7]) | (~a_v[7] & b_v[7] & res[7]);
              flags_d[cbl_pkg::FLAG_N] = res[7];
              flags_d[cbl_pkg::FLAG_S] = res[7] ^ flags_d[cbl_pkg::FLAG_V];
              flags_d[cbl_pkg::FLAG_C] = diff[8];
              // The carry form keeps Z clear across a multi-byte compare.
              flags_d[cbl_pkg::FLAG_Z] = (res == 8'h00) && ((req.op != cbl_pkg::op_compare_regs_with_carry)
                                         || status_flags_reg_q[cbl_pkg::FLAG_Z]);
            end
            cbl_pkg::op_skip_reg_bit, cbl_pkg::op_skip_io_bit: begin
              if (hit) begin
                done_d = 1'b0;
                state_d = st_stall;
                pc_d = pc_q + PC_W'(req.next_two_word ? cbl_pkg::SKIP_TWO_WORD : cbl_pkg::SKIP_ONE_WORD);
                cnt_d = req.next_two_word ? cbl_pkg::STALL_SKIP_TWO : cbl_pkg::STALL_SKIP_ONE;
              end
            end
            cbl_pkg::op_branch_flag: begin
              if (cond) begin
                done_d = 1'b0;
                state_d = st_stall;
                pc_d = tgt;
                cnt_d = cbl_pkg::STALL_BRANCH;
              end
            end
            cbl_pkg::op_register_copy: begin
              wr_d.we0 = 1'b1;
              wr_d.addr0 = req.rd;
              wr_d.data0 = rf[req.rr];
            end
            cbl_pkg::op_register_pair_copy: begin
              wr_d.we0 = 1'b1;
              wr_d.addr0 = {req.rd[4:1], 1'b0};
              wr_d.data0 = rf[{req.rr[4:1], 1'b0}];
              wr_d.we1 = 1'b1;
              wr_d.addr1 = {req.rd[4:1], 1'b1};
              wr_d.data1 = rf[{req.rr[4:1], 1'b1}];
            end
            cbl_pkg::op_load_immediate: begin
              wr_d.we0 = 1'b1;
              wr_d.addr0 = req.rd;
              wr_d.data0 = req.imm;
            end
            cbl_pkg::op_load_indirect, cbl_pkg::op_load_displaced: begin
              done_d = 1'b0;
              state_d = st_load;
              dst_d = req.rd;
              dmem_rd_d = 1'b1;
              dmem_addr_d = ptr;
              if (req.op == cbl_pkg::op_load_displaced) begin
                dmem_addr_d = ptr + {10'h000, req.disp};
              end else if (req.ptr_mode == cbl_pkg::MODE_POST_INC) begin
                ptr_new = ptr + 16'h0001;
              end else if (req.ptr_mode == cbl_pkg::MODE_PRE_DEC) begin
                ptr_new = ptr - 16'h0001;
                dmem_addr_d = ptr_new;
              end
              if (ptr_new != ptr) begin
                wr_d.we0 = 1'b1;
                wr_d.addr0 = ptr_lo(req.ptr_sel);
                wr_d.data0 = ptr_new[7:0];
                wr_d.we1 = 1'b1;
                wr_d.addr1 = ptr_lo(req.ptr_sel) + 5'h01;
                wr_d.data1 = ptr_new[15:8];
              end
            end
            default: begin
              done_d = 1'b0;
            end
          endcase
        end
      end
      st_stall: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          state_d = st_idle;
          done_d = 1'b1;
        end
      end
      st_load: begin
        wr_d.we0 = 1'b1;
        wr_d.addr0 = dst_q;
        wr_d.data0 = dmem_rdata;
        state_d = st_idle;
        done_d = 1'b1;
      end
    endcase
    ready_d = (state_d == st_idle);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      cnt_q <= 2'h0;
      dst_q <= 5'h00;
      pc_q <= '0;
      status_flags_reg_q <= cbl_pkg::FLAGS_RST;
      req_ready_q <= 1'b0;
      done_q <= 1'b0;
      dmem_rd_q <= 1'b0;
      dmem_addr_q <= 16'h0000;
      rf_wr_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dst_q <= dst_d;
      pc_q <= pc_d;
      status_flags_reg_q <= flags_d;
      req_ready_q <= ready_d;
      done_q <= done_d;
      dmem_rd_q <= dmem_rd_d;
      dmem_addr_q <= dmem_addr_d;
      rf_wr_q <= wr_d;
    end
  end

  // Register storage has no reset, as a real file would not; load it before use.
  always_ff @(posedge clk_sys) begin
    if (wr_d.we0) begin
      rf[wr_d.addr0] <= wr_d.data0;
    end
    if (wr_d.we1) begin
      rf[wr_d.addr1] <= wr_d.data1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_cmp_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_compare_immediate) && !flags_wr_en
    |=> done_q && req_ready_q && (status_flags_reg_q[cbl_pkg::FLAG_Z] == ($past(a_v) == $past(req.imm))))
    else $error("compare did not finish in one cycle with correct Z");

  a_copy_keeps_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_register_copy) && !flags_wr_en
    |=> done_q && req_ready_q && $stable(status_flags_reg_q))
    else $error("register copy changed flags or stalled");

  a_branch_taken_cost: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_branch_flag) && cond
    |=> !req_ready_q && (pc_q == $past(tgt)) ##1 req_ready_q && done_q)
    else $error("taken branch cost or target wrong");

  a_branch_untaken: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_branch_flag) && !cond
    |=> req_ready_q && (pc_q == $past(pc_q) + PC_W'(1)))
    else $error("untaken branch not one cycle");

  a_signed_less: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_branch_flag) && (req.flag_sel == 3'(cbl_pkg::FLAG_S)) && req.pol_set
    && (status_flags_reg_q[cbl_pkg::FLAG_N] != status_flags_reg_q[cbl_pkg::FLAG_V]) |=> !req_ready_q)
    else $error("signed less-than branch not taken");

  a_skip_two_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_skip_reg_bit) && hit && req.next_two_word
    |=> !req_ready_q[*2] ##1 req_ready_q && (pc_q == $past(pc_q, 3) + PC_W'(3)))
    else $error("skip over two-word instruction wrong");

  a_post_inc_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_load_indirect) && (req.ptr_mode == cbl_pkg::MODE_POST_INC)
    |=> dmem_rd_q && (dmem_addr_q == $past(ptr)) && (rf_wr_q.data0 == $past(ptr[7:0]) + 8'h01)
    ##1 rf_wr_q.we0 && req_ready_q && done_q)
    else $error("post-increment load sequence wrong");

  a_pre_dec_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_load_indirect) && (req.ptr_mode == cbl_pkg::MODE_PRE_DEC)
    |=> dmem_rd_q && (dmem_addr_q == $past(ptr) - 16'h0001))
    else $error("pre-decrement load address wrong");

  a_disp_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (req.op == cbl_pkg::op_load_displaced)
    |=> (dmem_addr_q == $past(ptr) + {10'h000, $past(req.disp)}) && !rf_wr_q.we0)
    else $error("displacement load address or pointer wrong");

endmodule

// ==== include/cbl_pkg.sv ====
package cbl_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int REG_CNT = 32;

  // Status flag bit positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // Pointer pairs: low byte register index of each.
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  // Pointer update modes for load_indirect.
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_PRE_DEC = 2'h2;

  // Program counter advances.
  localparam int PC_STEP = 1;
  localparam int SKIP_ONE_WORD = 2;
  localparam int SKIP_TWO_WORD = 3;
  // Extra stall cycles after the accept cycle.
  localparam logic [1:0] STALL_BRANCH = 2'h1;
  localparam logic [1:0] STALL_SKIP_ONE = 2'h1;
  localparam logic [1:0] STALL_SKIP_TWO = 2'h2;

  typedef enum logic [3:0] {
    op_compare_regs,
    op_compare_regs_with_carry,
    op_compare_immediate,
    op_skip_reg_bit,
    op_skip_io_bit,
    op_branch_flag,
    op_register_copy,
    op_register_pair_copy,
    op_load_immediate,
    op_load_indirect,
    op_load_displaced
  } op_t;

  typedef struct packed {
    op_t op;
    logic pol_set;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [2:0] flag_sel;
    logic [6:0] offset;
    logic [1:0] ptr_sel;
    logic [1:0] ptr_mode;
    logic [5:0] disp;
    logic next_two_word;
  } instr_t;

  typedef struct packed {
    logic we0;
    logic [4:0] addr0;
    logic [7:0] data0;
    logic we1;
    logic [4:0] addr1;
    logic [7:0] data1;
  } rf_wr_t;

endpackage

// ==== test/dmem_model.sv ====
`timescale 1ns/10ps
module dmem_model (
  // Clock and read port.
  input wire logic clk_sys,
  input wire logic dmem_rd_q,
  input wire logic [15:0] dmem_addr_q,
  output logic [7:0] dmem_rdata
);
  logic [7:0] junk_q = 8'h00;
  // Off a read the bus moves every cycle, so a late sample cannot pass.
  always @(posedge clk_sys) junk_q <= junk_q + 8'h3b;
  always_comb begin
    if (dmem_rd_q) begin
      dmem_rdata = dmem_addr_q[7:0] ^ dmem_addr_q[15:8] ^ 8'h5a;
    end else begin
      dmem_rdata = junk_q;
    end
  end
endmodule

// ==== test/compare_branch_load_exec_tb.sv ====
`timescale 1ns/10ps
module compare_branch_load_exec_tb;
  logic clk_sys, rst_n, req_valid, flags_wr_en, req_ready_q, done_q, dmem_rd_q;
  cbl_pkg::instr_t req;
  cbl_pkg::rf_wr_t rf_wr_q;
  logic [7:0] io_rdata, flags_wr_val, status_flags_reg_q, dmem_rdata, fl_e;
  logic [11:0] pc_q, pc_e;
  logic [15:0] dmem_addr_q, rd_addr;
  logic [7:0] obs_rf [32];
  int fail_count = 0;
  int total_checks = 0;
  int wr_cnt;
  compare_branch_load_exec #(.PC_W(12)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req(req), .io_rdata(io_rdata), .req_ready_q(req_ready_q), .done_q(done_q), .flags_wr_en(flags_wr_en),
    .flags_wr_val(flags_wr_val), .status_flags_reg_q(status_flags_reg_q), .pc_q(pc_q),
    .dmem_rd_q(dmem_rd_q), .dmem_addr_q(dmem_addr_q), .dmem_rdata(dmem_rdata), .rf_wr_q(rf_wr_q));
  dmem_model mem_u (.clk_sys(clk_sys), .dmem_rd_q(dmem_rd_q), .dmem_addr_q(dmem_addr_q),
    .dmem_rdata(dmem_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic cbl_pkg::instr_t mk(input cbl_pkg::op_t op, input logic [4:0] rd, input logic [4:0] rr);
    cbl_pkg::instr_t i;
    i = '0;
    i.op = op;
    i.rd = rd;
    i.rr = rr;
    return i;
  endfunction
  function automatic logic [7:0] cmp_flags(input logic [7:0] f, a, b, input logic wc);
    logic [7:0] r, n;
    r = a - b - {7'h00, wc & f[0]};
    n = f;
    n[0] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    n[5] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    n[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    n[2] = r[7];
    n[4] = n[2] ^ n[3];
    n[1] = (r == 8'h00) && (!wc || f[1]);
    return n;
  endfunction
  // Requests go out on a falling edge; a hung unit ends the run after eight cycles.
  // One edge always passes first, so valid never drops and rises in the same step.
  task automatic run(input cbl_pkg::instr_t i, input int cyc);
    int n;
    n = 0;
    wr_cnt = 0;
    rd_addr = 16'hffff;
    do begin
      @(negedge clk_sys);
      n++;
    end while (req_ready_q !== 1'b1 && n < 8);
    if (req_ready_q !== 1'b1) begin
      chk("ready", 16'h0001, 16'h0000);
      finish_test();
    end
    req = i;
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 1;
    while (n < 8) begin
      if (rf_wr_q.we0) begin
        obs_rf[rf_wr_q.addr0] = rf_wr_q.data0;
        wr_cnt++;
      end
      if (rf_wr_q.we1) begin
        obs_rf[rf_wr_q.addr1] = rf_wr_q.data1;
        wr_cnt++;
      end
      if (dmem_rd_q) rd_addr = dmem_addr_q;
      if (done_q === 1'b1) break;
      @(negedge clk_sys);
      n++;
    end
    if (n >= 8) begin
      chk("done", 16'h0001, 16'h0000);
      finish_test();
    end
    chk("cycles", 16'(cyc), 16'(n));
    chk("pc", 16'(pc_e), 16'(pc_q));
    chk("flags", {8'h00, fl_e}, {8'h00, status_flags_reg_q});
  endtask
  task automatic set_flags(input logic [7:0] v);
    flags_wr_en = 1'b1;
    flags_wr_val = v;
    @(negedge clk_sys);
    flags_wr_en = 1'b0;
    fl_e = v;
  endtask
  task automatic load_immediate(input logic [4:0] r, input logic [7:0] v);
    cbl_pkg::instr_t i;
    i = mk(cbl_pkg::op_load_immediate, r, 5'h00);
    i.imm = v;
    pc_e += 12'h001;
    run(i, 1);
    chk("ldi", {8'h00, v}, {8'h00, obs_rf[r]});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_moves();
    set_flags(8'hff);
    load_immediate(5'h10, 8'h3c);
    load_immediate(5'h11, 8'hc3);
    pc_e += 12'h001;
    run(mk(cbl_pkg::op_register_copy, 5'h04, 5'h11), 1);
    chk("copy", 16'h00c3, {8'h00, obs_rf[4]});
    pc_e += 12'h001;
    run(mk(cbl_pkg::op_register_pair_copy, 5'h08, 5'h10), 1);
    chk("pair", 16'hc33c, {obs_rf[9], obs_rf[8]});
    $display("moves ok");
  endtask
  task automatic t_compare();
    logic [15:0] ab [4];
    cbl_pkg::instr_t i;
    ab = '{16'h0000, 16'h1001, 16'h8001, 16'h0102};
    for (int k = 0; k < 12; k++) begin
      load_immediate(5'h10, ab[k % 4][15:8]);
      load_immediate(5'h11, ab[k % 4][7:0]);
      set_flags(8'hc3);
      i = mk(cbl_pkg::op_t'(k / 4), 5'h10, 5'h11);
      i.imm = ab[k % 4][7:0];
      fl_e = cmp_flags(8'hc3, ab[k % 4][15:8], ab[k % 4][7:0], k / 4 == 1);
      pc_e += 12'h001;
      run(i, 1);
      chk("cmp writes", 16'h0000, 16'(wr_cnt));
    end
    $display("compare ok");
  endtask
  task automatic t_branch();
    logic [7:0] pat [3];
    cbl_pkg::instr_t i;
    logic [7:0] f;
    logic tk;
    pat = '{8'h55, 8'haa, 8'h0c};
    for (int k = 0; k < 48; k++) begin
      f = pat[k / 16];
      set_flags(f);
      i = mk(cbl_pkg::op_branch_flag, 5'h00, 5'h00);
      i.flag_sel = 3'(k % 8);
      i.pol_set = k[3];
      i.offset = k[0] ? 7'h7d : 7'h05;
      tk = ((i.flag_sel == 3'h4) ? f[2] ^ f[3] : f[i.flag_sel]) == i.pol_set;
      pc_e += tk ? 12'h001 + {{5{i.offset[6]}}, i.offset} : 12'h001;
      run(i, tk ? 2 : 1);
    end
    $display("branch ok");
  endtask
  // For register skips the port carries the inverted value, so reading the wrong source flips the outcome.
  task automatic t_skip();
    cbl_pkg::instr_t i;
    logic sk;
    load_immediate(5'h14, 8'ha5);
    for (int k = 0; k < 16; k++) begin
      i = mk(k[3] ? cbl_pkg::op_skip_io_bit : cbl_pkg::op_skip_reg_bit, 5'h14, 5'h14);
      i.pol_set = k[2];
      i.next_two_word = k[1];
      i.bit_sel = {2'h0, k[0]};
      io_rdata = k[3] ? 8'ha5 : 8'h5a;
      sk = !k[0] == k[2];
      pc_e += sk ? (k[1] ? 12'h003 : 12'h002) : 12'h001;
      run(i, sk ? (k[1] ? 3 : 2) : 1);
      io_rdata = 8'h5a;
    end
    $display("skip ok");
  endtask
  task automatic t_load();
    logic [15:0] rows [6][4];
    cbl_pkg::instr_t i;
    logic [4:0] lo, rd;
    rows = '{'{16'h01ff, 16'h01ff, 16'h0200, 16'h0040}, '{16'h0200, 16'h01ff, 16'h01ff, 16'h0180},
      '{16'h0300, 16'h0300, 16'h0300, 16'h0200}, '{16'h01ff, 16'h023e, 16'h01ff, 16'h813f},
      '{16'h0300, 16'h02ff, 16'h02ff, 16'h0280}, '{16'h0300, 16'h0321, 16'h0300, 16'h8221}};
    for (int k = 0; k < 6; k++) begin
      lo = 5'h1a + {2'h0, rows[k][3][9:8], 1'b0};
      rd = 5'h05 + 5'(k);
      load_immediate(lo, rows[k][0][7:0]);
      load_immediate(lo + 5'h01, rows[k][0][15:8]);
      i = mk(rows[k][3][15] ? cbl_pkg::op_load_displaced : cbl_pkg::op_load_indirect, rd, 5'h00);
      i.ptr_sel = rows[k][3][9:8];
      i.ptr_mode = rows[k][3][7:6];
      i.disp = rows[k][3][5:0];
      pc_e += 12'h001;
      run(i, 2);
      chk("addr", rows[k][1], rd_addr);
      chk("data", {8'h00, rows[k][1][7:0] ^ rows[k][1][15:8] ^ 8'h5a}, {8'h00, obs_rf[rd]});
      chk("ptr", rows[k][2], {obs_rf[lo + 5'h01], obs_rf[lo]});
      chk("writes", (rows[k][0] == rows[k][2]) ? 16'h0001 : 16'h0003, 16'(wr_cnt));
    end
    $display("load ok");
  endtask
  // An undecoded code only steps the count; a reset in mid-run then clears every output.
  task automatic t_reset();
    cbl_pkg::instr_t i;
    i = mk(cbl_pkg::op_t'(4'hf), 5'h00, 5'h00);
    @(negedge clk_sys);
    req = i;
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    pc_e += 12'h001;
    chk("undef pc", 16'(pc_e), 16'(pc_q));
    chk("undef done ready", 16'h0001, {14'h0000, done_q, req_ready_q});
    rst_n = 1'b0;
    @(negedge clk_sys);
    chk("rst pc", 16'h0000, 16'(pc_q));
    chk("rst flags", 16'h0000, {8'h00, status_flags_reg_q});
    chk("rst outs", 16'h0000, {12'h000, req_ready_q, done_q, dmem_rd_q, rf_wr_q.we0});
    rst_n = 1'b1;
    chk("ready at release", 16'h0000, {15'h0000, req_ready_q});
    @(negedge clk_sys);
    chk("ready after release", 16'h0001, {15'h0000, req_ready_q});
    pc_e = 12'h001;
    fl_e = 8'h00;
    run(mk(cbl_pkg::op_register_copy, 5'h04, 5'h04), 1);
    $display("reset ok");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    io_rdata = 8'h5a;
    flags_wr_en = 1'b0;
    flags_wr_val = 8'h00;
    pc_e = 12'h000;
    fl_e = 8'h00;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    chk("reset pc", 16'h0000, 16'(pc_q));
    t_moves();
    t_compare();
    t_branch();
    t_skip();
    t_load();
    t_reset();
    finish_test();
  end
endmodule
